/* File: rtl/ufc_pkg.sv */
//
// Purpose: Shared constants and types for the UART FIFO control block
// Assumes: One channel, FIFO counts fit in seven bits
// Notes: Register byte address is four times the register index
//
package ufc_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_INT_EN = 8'h01;
	localparam logic [7:0] IDX_FIFO_CTRL = 8'h02;
	localparam logic [7:0] IDX_STATUS = 8'h03;

	// ---------------------------------------------------------------
	// Field positions and values after reset
	// ---------------------------------------------------------------
	localparam int BIT_FIFO_EN = 0;
	localparam int BIT_RX_CLR = 1;
	localparam int BIT_TX_CLR = 2;
	localparam int BIT_DMA_MODE = 3;
	localparam int TX_TRIG_LSB = 4;
	localparam int RX_TRIG_LSB = 6;
	localparam int BIT_IE_RX = 0;
	localparam int BIT_IE_TX = 1;
	localparam logic [1:0] RST_TRIG = 2'h0;
	localparam logic RST_DMA_MODE = 1'h0;
	localparam logic RST_FIFO_EN = 1'h0;
	localparam logic [1:0] RST_INT_EN = 2'h0;

	// ---------------------------------------------------------------
	// Counts and thresholds
	// ---------------------------------------------------------------
	localparam int CNT_W = 7;
	localparam logic [6:0] DEPTH_DEEP = 7'h40;
	localparam logic [6:0] DEPTH_SHALLOW = 7'h10;
	localparam logic [6:0] RX_DEEP_0 = 7'h08;
	localparam logic [6:0] RX_DEEP_1 = 7'h10;
	localparam logic [6:0] RX_DEEP_2 = 7'h38;
	localparam logic [6:0] RX_DEEP_3 = 7'h3C;
	localparam logic [6:0] RX_SHAL_0 = 7'h01;
	localparam logic [6:0] RX_SHAL_1 = 7'h04;
	localparam logic [6:0] RX_SHAL_2 = 7'h08;
	localparam logic [6:0] RX_SHAL_3 = 7'h0E;
	localparam logic [6:0] TX_DEEP_0 = 7'h08;
	localparam logic [6:0] TX_DEEP_1 = 7'h10;
	localparam logic [6:0] TX_DEEP_2 = 7'h20;
	localparam logic [6:0] TX_DEEP_3 = 7'h38;

	typedef struct packed {
		logic [1:0] rx_trig;
		logic [1:0] tx_trig;
		logic dma_mode;
		logic fifo_en;
	} ufc_ctrl_t;

	// Receive threshold for a trigger code
	function automatic logic [6:0] ufc_rx_level(input logic [1:0] sel,
		input logic deep);
		logic [6:0] lvl;
		lvl = RX_SHAL_0;
		case (sel)
			2'h0: lvl = deep ? RX_DEEP_0 : RX_SHAL_0;
			2'h1: lvl = deep ? RX_DEEP_1 : RX_SHAL_1;
			2'h2: lvl = deep ? RX_DEEP_2 : RX_SHAL_2;
			default: lvl = deep ? RX_DEEP_3 : RX_SHAL_3;
		endcase
		return lvl;
	endfunction

	// Transmit threshold for a trigger code
	function automatic logic [6:0] ufc_tx_level(input logic [1:0] sel);
		logic [6:0] lvl;
		lvl = TX_DEEP_0;
		case (sel)
			2'h0: lvl = TX_DEEP_0;
			2'h1: lvl = TX_DEEP_1;
			2'h2: lvl = TX_DEEP_2;
			default: lvl = TX_DEEP_3;
		endcase
		return lvl;
	endfunction

endpackage

/* File: rtl/ufc_level.sv */
//
// Purpose: Threshold decode and FIFO level compare
// Assumes: Counts come from FIFO logic on the same clock
// Notes: Purely combinational
//
`timescale 1ns/10ps
module ufc_level #(
	parameter bit DEEP = 1'b1
) (
	input wire ufc_pkg::ufc_ctrl_t i_ctrl,
	input wire logic [6:0] i_rx_count,
	input wire logic [6:0] i_tx_count,
	output logic [6:0] o_rx_thr,
	output logic [6:0] o_tx_thr,
	output logic o_rx_at_trig,
	output logic o_tx_room,
	output logic o_tx_empty,
	output logic o_tx_full
);
	wire [6:0] depth = DEEP ? ufc_pkg::DEPTH_DEEP : ufc_pkg::DEPTH_SHALLOW;
	wire [6:0] tx_free = depth - i_tx_count;

	assign o_rx_thr = ufc_pkg::ufc_rx_level(i_ctrl.rx_trig, DEEP);
	assign o_tx_thr = ufc_pkg::ufc_tx_level(i_ctrl.tx_trig);
	assign o_rx_at_trig = (i_rx_count >= o_rx_thr);
	assign o_tx_empty = (i_tx_count == 7'h00);
	assign o_tx_full = (i_tx_count >= depth);
	assign o_tx_room = DEEP ? (tx_free > o_tx_thr) : o_tx_empty;
endmodule

/* File: rtl/ufc_dma.sv */
//
// Purpose: Active-low DMA request generation for both directions
// Assumes: Mode 1 input already gated by FIFO enable
// Notes: Mode 1 requests hold until the FIFO empties or fills
//
`timescale 1ns/10ps
module ufc_dma (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_mode1,
	input wire logic i_rx_empty,
	input wire logic i_rx_at_trig,
	input wire logic i_rx_timeout,
	input wire logic i_tx_room,
	input wire logic i_tx_empty,
	input wire logic i_tx_full,
	output logic o_rx_req_n,
	output logic o_tx_req_n
);
	logic rx_hold_r, rx_hold_nxt, tx_hold_r, tx_hold_nxt;

	assign rx_hold_nxt = i_rx_empty ? 1'b0 :
		(rx_hold_r | i_rx_at_trig | i_rx_timeout);
	assign tx_hold_nxt = i_tx_full ? 1'b0 : (tx_hold_r | i_tx_room);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_hold_r <= 1'b0;
			tx_hold_r <= 1'b0;
			o_rx_req_n <= 1'b1;
			o_tx_req_n <= 1'b1;
		end else begin
			rx_hold_r <= rx_hold_nxt;
			tx_hold_r <= tx_hold_nxt;
			o_rx_req_n <= i_mode1 ? ~rx_hold_nxt : i_rx_empty;
			o_tx_req_n <= i_mode1 ? ~tx_hold_nxt : ~i_tx_empty;
		end
	end
endmodule

/* File: rtl/ufc_top.sv */
//
// Purpose: FIFO control register of one UART channel behind APB
// Assumes: FIFO counts, timeout and ident come from same-clock logic
// Notes: Zero wait-state APB slave, read data sampled in setup
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module ufc_top #(
	parameter bit DEEP = 1'b1
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [7:0] I_INT_IDENT,
	input wire logic [6:0] I_RX_COUNT,
	input wire logic [6:0] I_TX_COUNT,
	input wire logic I_RX_TIMEOUT,
	output logic O_FIFO_EN,
	output logic O_TX_FIFO_CLR,
	output logic O_RX_FIFO_CLR,
	output logic O_RX_INT,
	output logic O_TX_INT,
	output logic O_TX_DMA_REQUEST_N,
	output logic O_RX_DMA_REQUEST_N
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	ufc_pkg::ufc_ctrl_t ctrl_r, ctrl_nxt;
	logic [1:0] int_en_r, int_en_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic tx_clr_r, rx_clr_r;
	logic rx_int_r, tx_int_r;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire [7:0] idx = I_PADDR[9:2];
	wire addr_ok = (I_PADDR[1:0] == 2'h0) && (I_PADDR[11:10] == 2'h0);
	wire hit_ie = addr_ok && (idx == ufc_pkg::IDX_INT_EN);
	wire hit_fc = addr_ok && (idx == ufc_pkg::IDX_FIFO_CTRL);
	wire hit_st = addr_ok && (idx == ufc_pkg::IDX_STATUS);
	wire mapped = hit_ie | hit_fc | (hit_st & ~I_PWRITE);
	wire setup = I_PSEL & ~I_PENABLE;
	wire access = I_PSEL & I_PENABLE;
	wire wr_done = access & I_PWRITE & ~err_r;
	wire wr_fc = wr_done & hit_fc;
	wire wr_ie = wr_done & hit_ie;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	wire [7:0] wb = I_PWDATA[7:0];
	wire fc_ok = wr_fc & ctrl_r.fifo_en;

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_fc) begin
			ctrl_nxt.fifo_en = wb[ufc_pkg::BIT_FIFO_EN];
		end
		if (fc_ok) begin
			ctrl_nxt.rx_trig = wb[ufc_pkg::RX_TRIG_LSB +: 2];
			ctrl_nxt.tx_trig = wb[ufc_pkg::TX_TRIG_LSB +: 2];
			ctrl_nxt.dma_mode = wb[ufc_pkg::BIT_DMA_MODE];
		end
	end

	assign int_en_nxt = wr_ie ? I_PWDATA[1:0] : int_en_r;

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	wire [6:0] rx_thr;
	wire [6:0] tx_thr;
	wire [31:0] status_word = {19'h00000, rx_thr, ctrl_r.rx_trig,
		ctrl_r.tx_trig, ctrl_r.dma_mode, ctrl_r.fifo_en};

	always_comb begin
		rdata_nxt = 32'h00000000;
		if (hit_fc) begin
			rdata_nxt = {24'h000000, I_INT_IDENT};
		end else if (hit_ie) begin
			rdata_nxt = {30'h00000000, int_en_r};
		end else if (hit_st) begin
			rdata_nxt = status_word;
		end
	end

	assign err_nxt = setup ? ~mapped : err_r;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rdata_r <= 32'h00000000;
			err_r <= 1'b0;
		end else if (setup) begin
			rdata_r <= I_PWRITE ? 32'h00000000 : rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign O_PRDATA = rdata_r;
	assign O_PREADY = access;
	assign O_PSLVERR = access & err_r;

	// ---------------------------------------------------------------
	// Register update
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ctrl_r.rx_trig <= ufc_pkg::RST_TRIG;
			ctrl_r.tx_trig <= ufc_pkg::RST_TRIG;
			ctrl_r.dma_mode <= ufc_pkg::RST_DMA_MODE;
			ctrl_r.fifo_en <= ufc_pkg::RST_FIFO_EN;
			int_en_r <= ufc_pkg::RST_INT_EN;
		end else begin
			ctrl_r <= ctrl_nxt;
			int_en_r <= int_en_nxt;
		end
	end

	// ---------------------------------------------------------------
	// FIFO clear pulses
	// ---------------------------------------------------------------
	// clear needs enable
	wire tx_clr_nxt = fc_ok & wb[ufc_pkg::BIT_TX_CLR];
	wire rx_clr_nxt = fc_ok & wb[ufc_pkg::BIT_RX_CLR];

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			tx_clr_r <= 1'b0;
			rx_clr_r <= 1'b0;
		end else begin
			tx_clr_r <= tx_clr_nxt;
			rx_clr_r <= rx_clr_nxt;
		end
	end

	assign O_TX_FIFO_CLR = tx_clr_r;
	assign O_RX_FIFO_CLR = rx_clr_r;
	assign O_FIFO_EN = ctrl_r.fifo_en;

	// ---------------------------------------------------------------
	// Levels and interrupts
	// ---------------------------------------------------------------
	logic rx_at_trig, tx_room, tx_empty, tx_full;

	ufc_level #(
		.DEEP(DEEP)
	) u_level (
		.i_ctrl(ctrl_r),
		.i_rx_count(I_RX_COUNT),
		.i_tx_count(I_TX_COUNT),
		.o_rx_thr(rx_thr),
		.o_tx_thr(tx_thr),
		.o_rx_at_trig(rx_at_trig),
		.o_tx_room(tx_room),
		.o_tx_empty(tx_empty),
		.o_tx_full(tx_full)
	);

	wire rx_empty = (I_RX_COUNT == 7'h00);
	wire rx_int_nxt = int_en_r[ufc_pkg::BIT_IE_RX] &
		(ctrl_r.fifo_en ? rx_at_trig : ~rx_empty);
	wire tx_int_nxt = int_en_r[ufc_pkg::BIT_IE_TX] &
		(ctrl_r.fifo_en ? tx_room : tx_empty);

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rx_int_r <= 1'b0;
			tx_int_r <= 1'b0;
		end else begin
			rx_int_r <= rx_int_nxt;
			tx_int_r <= tx_int_nxt;
		end
	end

	assign O_RX_INT = rx_int_r;
	assign O_TX_INT = tx_int_r;

	// ---------------------------------------------------------------
	// DMA requests
	// ---------------------------------------------------------------
	// mode 1 gated by enable
	wire mode1 = ctrl_r.dma_mode & ctrl_r.fifo_en;

	ufc_dma u_dma (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_mode1(mode1),
		.i_rx_empty(rx_empty),
		.i_rx_at_trig(rx_at_trig),
		.i_rx_timeout(I_RX_TIMEOUT),
		.i_tx_room(tx_room),
		.i_tx_empty(tx_empty),
		.i_tx_full(tx_full),
		.o_rx_req_n(O_RX_DMA_REQUEST_N),
		.o_tx_req_n(O_TX_DMA_REQUEST_N)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_ident_read: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		setup & hit_fc & ~I_PWRITE |=> O_PRDATA == {24'h000000,
		$past(I_INT_IDENT)})
		else $error("ident not returned at control address");

	chk_rx_level_deep: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		DEEP && ctrl_r.rx_trig == 2'h3 |-> rx_thr == 7'h3C)
		else $error("deep receive threshold wrong");

	chk_rx_int_set: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		ctrl_r.fifo_en & int_en_r[0] & (I_RX_COUNT == rx_thr)
		|=> O_RX_INT)
		else $error("receive interrupt missing at threshold");

	chk_tx_level_deep: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		ctrl_r.tx_trig == 2'h2 |-> tx_thr == 7'h20)
		else $error("transmit threshold wrong");

	chk_tx_room_int: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		DEEP & ctrl_r.fifo_en & int_en_r[1] &
		((7'h40 - I_TX_COUNT) > tx_thr) |=> O_TX_INT)
		else $error("transmit interrupt missing with room");

	chk_shallow_tx: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!DEEP |-> tx_room == tx_empty)
		else $error("shallow variant used transmit trigger");

	chk_mode1_gate: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!ctrl_r.fifo_en ##1 !ctrl_r.fifo_en |->
		O_RX_DMA_REQUEST_N == $past(rx_empty))
		else $error("single transfer request broken");

	chk_tx_clear_pulse: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & ctrl_r.fifo_en & wb[2] |=> O_TX_FIFO_CLR ##1
		!O_TX_FIFO_CLR)
		else $error("transmit clear not one pulse");

	chk_clear_needs_en: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & !ctrl_r.fifo_en |=> !O_RX_FIFO_CLR & !O_TX_FIFO_CLR)
		else $error("clear acted with FIFOs disabled");

	chk_locked_fields: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!ctrl_r.fifo_en & !wr_fc |=> $stable(ctrl_r))
		else $error("control changed without a write");

	chk_disabled_write: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & !ctrl_r.fifo_en |=> ctrl_r.dma_mode ==
		$past(ctrl_r.dma_mode) && ctrl_r.rx_trig == $past(ctrl_r.rx_trig))
		else $error("locked field written while disabled");

	chk_rx_clear_pulse: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & ctrl_r.fifo_en & wb[ufc_pkg::BIT_RX_CLR] |=>
		O_RX_FIFO_CLR ##1 !O_RX_FIFO_CLR)
		else $error("receive clear not one pulse");

	chk_clear_zero_bits: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & !wb[ufc_pkg::BIT_TX_CLR] &
		!wb[ufc_pkg::BIT_RX_CLR] |=>
		!O_TX_FIFO_CLR & !O_RX_FIFO_CLR)
		else $error("clear acted on a zero bit");

	chk_clear_idle: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!wr_fc |=> !O_TX_FIFO_CLR & !O_RX_FIFO_CLR)
		else $error("clear pulse without a write");

	chk_enable_write: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc |=> O_FIFO_EN == $past(wb[ufc_pkg::BIT_FIFO_EN]))
		else $error("enable bit not taken from write");

	chk_dma_mode_write: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		wr_fc & ctrl_r.fifo_en |=>
		ctrl_r.dma_mode == $past(wb[ufc_pkg::BIT_DMA_MODE]))
		else $error("DMA mode bit not taken from write");

	chk_rx_low_deep: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		DEEP && !ctrl_r.rx_trig[1] |->
		rx_thr == (ctrl_r.rx_trig[0] ? 7'h10 : 7'h08))
		else $error("deep low receive threshold wrong");

	chk_rx_mid_deep: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		DEEP && ctrl_r.rx_trig == 2'h2 |-> rx_thr == 7'h38)
		else $error("deep middle receive threshold wrong");

	chk_tx_codes_deep: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		ctrl_r.tx_trig != 2'h2 |-> tx_thr == (ctrl_r.tx_trig[1] ?
		7'h38 : (ctrl_r.tx_trig[0] ? 7'h10 : 7'h08)))
		else $error("transmit threshold code wrong");

	chk_mode0_tx: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!mode1 |=> O_TX_DMA_REQUEST_N == !$past(tx_empty))
		else $error("single transfer transmit request wrong");

	chk_mode1_rx_release: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		mode1 & rx_empty |=> O_RX_DMA_REQUEST_N)
		else $error("block receive request not released");

	chk_mode1_tx_release: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		mode1 & tx_full |=> O_TX_DMA_REQUEST_N)
		else $error("block transmit request not released");

endmodule

/* File: testbench/ufc_fifo_model.sv */
//
// Purpose: FIFO side stand-in that holds occupancy counts
// Assumes: Bench loads counts, same clock as the block
// Notes: Clear pulses empty the matching count
//
`timescale 1ns/10ps
module ufc_fifo_model (
	input wire logic i_clk,
	input wire logic i_load,
	input wire logic [6:0] i_rx_val,
	input wire logic [6:0] i_tx_val,
	input wire logic i_rx_clr,
	input wire logic i_tx_clr,
	output logic [6:0] o_rx_count,
	output logic [6:0] o_tx_count
);
	always_ff @(posedge i_clk) begin
		if (i_load) begin
			o_rx_count <= i_rx_val;
			o_tx_count <= i_tx_val;
		end
		if (i_rx_clr)
			o_rx_count <= 7'h00;
		if (i_tx_clr)
			o_tx_count <= 7'h00;
	end
endmodule

/* File: testbench/tb_top.sv */
//
// Purpose: Self-checking bench for the FIFO control block
// Assumes: Deep variant, shallow copy for the transmit field, APB
// Notes: Counts are loaded through the FIFO model
//
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, err;
	logic [7:0] ident = 8'h5A;
	logic tmo = 1'b0;
	logic load = 1'b1;
	logic [6:0] rxv = 7'h00;
	logic [6:0] txv = 7'h40;
	logic [6:0] rxc, txc;
	logic fen, txclr, rxclr, rxint, txint, txreq, rxreq;
	logic stxint;
	int waits = 0;
	logic [6:0] rxt [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	always #4 clk = ~clk;

	ufc_top u_dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_INT_IDENT(ident), .I_RX_COUNT(rxc),
		.I_TX_COUNT(txc), .I_RX_TIMEOUT(tmo), .O_FIFO_EN(fen),
		.O_TX_FIFO_CLR(txclr), .O_RX_FIFO_CLR(rxclr), .O_RX_INT(rxint),
		.O_TX_INT(txint), .O_TX_DMA_REQUEST_N(txreq),
		.O_RX_DMA_REQUEST_N(rxreq));

	ufc_top #(.DEEP(1'b0)) u_dut_shallow (.I_CLK(clk), .I_RST(rst),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(), .O_PREADY(), .O_PSLVERR(),
		.I_INT_IDENT(ident), .I_RX_COUNT(rxc), .I_TX_COUNT(txc),
		.I_RX_TIMEOUT(tmo), .O_FIFO_EN(), .O_TX_FIFO_CLR(),
		.O_RX_FIFO_CLR(), .O_RX_INT(), .O_TX_INT(stxint),
		.O_TX_DMA_REQUEST_N(), .O_RX_DMA_REQUEST_N());

	ufc_fifo_model u_fifo (.i_clk(clk), .i_load(load), .i_rx_val(rxv),
		.i_tx_val(txv), .i_rx_clr(rxclr), .i_tx_clr(txclr),
		.o_rx_count(rxc), .o_tx_count(txc));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task stop_test;
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test;
		end
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		waits = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			waits++;
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		#1;
	endtask

	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task set(input logic [6:0] rx, input logic [6:0] tx);
		@(posedge clk);
		load <= 1'b1;
		rxv <= rx;
		txv <= tx;
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_reset;
		chk("fifo_en", fen, 0);
		chk("dma_n", {txreq, rxreq, txclr, rxclr}, 4'hC);
		rd(12'h00C);
		chk("status", rdata, 32'h200);
		rd(12'h008);
		chk("ident", rdata[7:0], ident);
		chk("pready_wait", waits, 1);
		rd(12'h010);
		chk("unmapped", err, 1);
	endtask

	task t_disabled;
		wr(12'h008, 32'hFF);
		chk("clr", {txclr, rxclr}, 0);
		rd(12'h00C);
		chk("status", rdata, 32'h201);
	endtask

	task t_clear;
		wr(12'h008, 32'h01);
		chk("clr0", {txclr, rxclr}, 0);
		wr(12'h008, 32'h07);
		chk("clr", {txclr, rxclr}, 2'h3);
		@(posedge clk);
		#1;
		chk("clr1", {txclr, rxclr}, 0);
	endtask

	task t_trig;
		for (int i = 0; i < 4; i++) begin
			wr(12'h008, 32'h01 | (i << 6) | (i << 4));
			rd(12'h00C);
			chk("trig", rdata, {19'h0, rxt[i], i[1:0], i[1:0], 2'h1});
		end
	endtask

	task t_int;
		wr(12'h008, 32'h01);
		wr(12'h004, 32'h03);
		set(7'h07, 7'h40);
		chk("ints", {rxint, txint}, 0);
		set(7'h08, 7'h38);
		chk("ints", {rxint, txint}, 2'h2);
		set(7'h08, 7'h37);
		chk("txint", txint, 1);
		chk("shallow_tx", stxint, 0);
		wr(12'h004, 32'h02);
		repeat (2) @(posedge clk);
		#1;
		chk("rxmask", rxint, 0);
		wr(12'h008, 32'h21);
		set(7'h00, 7'h20);
		chk("tx32", txint, 0);
		set(7'h00, 7'h1F);
		chk("tx31", txint, 1);
		chk("shallow_tx31", stxint, 0);
		set(7'h00, 7'h00);
		chk("shallow_empty", stxint, 1);
	endtask

	task t_dma1;
		set(7'h01, 7'h3F);
		chk("mode0", {rxreq, txreq}, 2'h1);
		wr(12'h008, 32'h09);
		set(7'h00, 7'h40);
		chk("idle", {rxreq, txreq}, 2'h3);
		set(7'h08, 7'h40);
		chk("rxtrig", rxreq, 0);
		set(7'h03, 7'h40);
		chk("rxhold", rxreq, 0);
		set(7'h00, 7'h40);
		chk("rxempty", rxreq, 1);
		set(7'h00, 7'h37);
		chk("txroom", txreq, 0);
		set(7'h00, 7'h3C);
		chk("txhold", txreq, 0);
		set(7'h00, 7'h40);
		chk("txfull", txreq, 1);
		set(7'h02, 7'h40);
		chk("notrig", rxreq, 1);
		@(posedge clk);
		tmo <= 1'b1;
		@(posedge clk);
		tmo <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("rxtmo", rxreq, 0);
		set(7'h00, 7'h40);
	endtask

	task t_nofifo;
		wr(12'h008, 32'h08);
		chk("fifo_en", fen, 0);
		rd(12'h00C);
		chk("status", rdata, 32'h202);
		set(7'h01, 7'h00);
		chk("single", {rxreq, txreq}, 0);
		set(7'h00, 7'h40);
		chk("release", {rxreq, txreq}, 2'h3);
	endtask

	task t_rerst;
		wr(12'h008, 32'h01);
		wr(12'h008, 32'hF9);
		rd(12'h00C);
		chk("pre_rst", rdata, 32'hF3F);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst_en", fen, 0);
		chk("rst_clr", {txclr, rxclr}, 0);
		rd(12'h00C);
		chk("rst_status", rdata, 32'h200);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		load <= 1'b0;
		@(posedge clk);
		#1;
		t_reset;
		t_disabled;
		t_clear;
		t_trig;
		t_int;
		t_dma1;
		t_nofifo;
		t_rerst;
		stop_test;
	end
endmodule
